// >>> verilog/bpc_port.sv
// Eight-bit bidirectional port with change detection behind an AXI4-Lite slave
`timescale 1ns/10ps

// Contract
// [R1] Direction bit one tri-states the pin driver
// [R2] Direction bit zero drives pin from latch
// [R3] Port read returns pins; write updates latch
// [R4] Writes are read-modify-write using pin levels
// [R5] Pull-ups enabled by clearing option bit seven
// [R6] Output pins never get a pull-up; here it stays on for one cycle after the direction bit clears
// [R7] Pull-ups off after reset
// [R8] Only upper four input pins detect change
// [R9] Compare input pins with last read copy
// [R10] Mismatches ORed set change flag bit zero
// [R11] Change flag can wake from sleep
// [R12] Any port access refreshes comparison copy
// [R13] Persistent mismatch keeps setting the flag
// [R14] Change during port read may be missed
// [R15] Bit zero Schmitt input for edge interrupt
// [R16] Bits six, seven Schmitt in programming mode
// [R17] Reset loads direction and option all ones
// [R18] Software should not poll the port
// [R19] External parts must not fight driven pins
// [R20] Synchronise pins before change comparison
module bpc_port
  import bpc_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address channel
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data channel
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response channel
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address channel
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data channel
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Port pins, split into input, output and active-low enable
  input  wire logic [PORT_W-1:0] pin_in,
  output logic [PORT_W-1:0]      pin_out,
  output logic [PORT_W-1:0]      pin_oe_n,
  output logic [PORT_W-1:0]      pullup_on,
  // Input buffer selection
  input  wire logic              edge_irq_mode,
  input  wire logic              serial_prog_mode,
  output logic [PORT_W-1:0]      schmitt_sel,
  // Power management
  input  wire logic              sleep_active,
  output logic                   wake_req,
  output logic                   port_change_flag
);

  // Address match of a byte address against a register index
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [7:0] idx);
    reg_hit = (addr[ADDR_W-1:2] == {2'h0, idx}) && (addr[1:0] == 2'h0);
  endfunction

  // Register state
  logic [PORT_W-1:0] dir_r;        // second_port_direction
  logic [PORT_W-1:0] dir_nxt;
  logic [PORT_W-1:0] opt_r;        // timer_and_pullup_config
  logic [PORT_W-1:0] opt_nxt;
  logic [PORT_W-1:0] latch_r;      // Output latch
  logic [PORT_W-1:0] latch_nxt;
  logic              flag_r;       // port_change_flag
  logic              flag_nxt;
  logic [PORT_W-1:0] ref_r;        // Copy of pins at last port access
  logic [PORT_W-1:0] ref_nxt;
  // Pin synchroniser stages
  logic [PORT_W-1:0] sync1_r;      // First stage, read only by the second
  logic [PORT_W-1:0] sync2_r;      // Settled pin levels

  // Registered side outputs
  logic [PORT_W-1:0] schmitt_r;    // Input buffer type
  logic [PORT_W-1:0] schmitt_nxt;
  logic [PORT_W-1:0] pullup_r;     // Pull-up enables
  logic [PORT_W-1:0] pullup_nxt;
  logic              wake_r;       // Wake request
  logic              wake_nxt;
  // Write channel state and holding registers
  bpc_wr_e           wr_st_r;
  bpc_wr_e           wr_st_nxt;
  logic [ADDR_W-1:0] awaddr_r;     // Held write address
  logic [DATA_W-1:0] wdata_r;      // Held write data
  logic [3:0]        wstrb_r;      // Held write strobes
  logic [1:0]        bresp_r;      // Write response code
  logic [1:0]        bresp_nxt;
  // Read channel state and data
  bpc_rd_e           rd_st_r;
  bpc_rd_e           rd_st_nxt;
  logic [DATA_W-1:0] rdata_r;      // Read data
  logic [DATA_W-1:0] rdata_nxt;
  logic [1:0]        rresp_r;      // Read response code
  logic [1:0]        rresp_nxt;
  // Channel handshakes
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire b_done  = s_axi_bvalid && s_axi_bready;
  wire r_done  = s_axi_rvalid && s_axi_rready;
  // Address is open in idle and while data alone is held
  assign s_axi_awready = (wr_st_r == WR_IDLE) || (wr_st_r == WR_DATA);
  // Data is open in idle and while the address alone is held
  assign s_axi_wready  = (wr_st_r == WR_IDLE) || (wr_st_r == WR_ADDR);
  assign s_axi_bvalid  = (wr_st_r == WR_RESP);
  assign s_axi_bresp   = bresp_r;
  // One read at a time; new address only once data has gone
  assign s_axi_arready = (rd_st_r == RD_IDLE);
  assign s_axi_rvalid  = (rd_st_r == RD_RESP);
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  // The write completes in the cycle its second half arrives
  wire wr_fire = (wr_st_r == WR_IDLE && aw_take && w_take) ||
                 (wr_st_r == WR_ADDR && w_take) ||
                 (wr_st_r == WR_DATA && aw_take);
  // Effective write address, data and strobes from held or live channel
  wire [ADDR_W-1:0] wr_addr = (wr_st_r == WR_ADDR) ? awaddr_r : s_axi_awaddr;
  wire [DATA_W-1:0] wr_data = (wr_st_r == WR_DATA) ? wdata_r  : s_axi_wdata;
  wire [3:0]        wr_strb = (wr_st_r == WR_DATA) ? wstrb_r  : s_axi_wstrb;
  // Write decode; only the low byte lane carries register bits
  wire wr_port = wr_fire && reg_hit(wr_addr, IDX_PORT_DATA);
  wire wr_opt  = wr_fire && reg_hit(wr_addr, IDX_OPTION);
  wire wr_dir  = wr_fire && reg_hit(wr_addr, IDX_DIRECTION);
  wire wr_icr  = wr_fire && reg_hit(wr_addr, IDX_INT_CTRL);
  wire wr_map  = wr_port || wr_opt || wr_dir || wr_icr;
  wire wr_lane = wr_strb[0];
  wire [PORT_W-1:0] wr_byte = wr_data[PORT_W-1:0];
  // Read decode
  wire rd_port = ar_take && reg_hit(s_axi_araddr, IDX_PORT_DATA);
  wire rd_opt  = ar_take && reg_hit(s_axi_araddr, IDX_OPTION);
  wire rd_dir  = ar_take && reg_hit(s_axi_araddr, IDX_DIRECTION);
  wire rd_icr  = ar_take && reg_hit(s_axi_araddr, IDX_INT_CTRL);
  wire rd_map  = rd_port || rd_opt || rd_dir || rd_icr;
  // Any port access, read or write, even with the lane strobe off
  wire port_access = rd_port || wr_port;
  // Input pins are those with a direction bit of one
  wire [PORT_W-1:0] in_mask = dir_r;
  // [R20] settled pin levels
  wire [PORT_W-1:0] pins = sync2_r;
  // [R8] upper inputs only; [R9] compare with copy
  wire [PORT_W-1:0] mismatch = (pins ^ ref_r) & in_mask & CHANGE_MASK;
  // [R10] mismatches ORed together
  wire mismatch_any = |mismatch;
  // [R3] port reads return pin levels
  wire [PORT_W-1:0] port_rd_val = pins;
  // [R4] input pins overwrite their latch bits
  wire [PORT_W-1:0] rmw_val = (pins & in_mask) | (wr_byte & ~in_mask);

  // Write channel sequencing
  always_comb begin
    wr_st_nxt = wr_st_r;
    bresp_nxt = bresp_r;
    unique case (wr_st_r)
      // Either half may arrive first, or both together
      WR_IDLE: begin
        if (wr_fire) begin
          wr_st_nxt = WR_RESP;
        end else if (aw_take) begin
          wr_st_nxt = WR_ADDR;
        end else if (w_take) begin
          wr_st_nxt = WR_DATA;
        end
      end
      // Waiting for data
      WR_ADDR: begin
        if (wr_fire) begin
          wr_st_nxt = WR_RESP;
        end
      end
      // Waiting for the address
      WR_DATA: begin
        if (wr_fire) begin
          wr_st_nxt = WR_RESP;
        end
      end
      // Hold the response until the master takes it
      WR_RESP: begin
        if (b_done) begin
          wr_st_nxt = WR_IDLE;
        end
      end
    endcase
    // Unmapped addresses answer with a slave error
    if (wr_fire) begin
      bresp_nxt = wr_map ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Read channel sequencing and data selection
  always_comb begin
    rd_st_nxt = rd_st_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    unique case (rd_st_r)
      // Capture data in the cycle the address is taken
      RD_IDLE: begin
        if (ar_take) begin
          rd_st_nxt = RD_RESP;
          rresp_nxt = rd_map ? RESP_OKAY : RESP_SLVERR;
          // Unused upper bits and unmapped words read as zero
          rdata_nxt = '0;
          if (rd_port) begin
            rdata_nxt[PORT_W-1:0] = port_rd_val;
          end else if (rd_opt) begin
            rdata_nxt[PORT_W-1:0] = opt_r;
          end else if (rd_dir) begin
            rdata_nxt[PORT_W-1:0] = dir_r;
          end else if (rd_icr) begin
            rdata_nxt[CHG_FLAG_BIT] = flag_r;
          end
        end
      end
      // Hold data until the master takes it
      RD_RESP: begin
        if (r_done) begin
          rd_st_nxt = RD_IDLE;
        end
      end
    endcase
  end

  // Register write effects
  always_comb begin
    dir_nxt   = dir_r;
    opt_nxt   = opt_r;
    latch_nxt = latch_r;
    if (wr_lane) begin
      if (wr_dir) begin
        dir_nxt = wr_byte;
      end
      if (wr_opt) begin
        opt_nxt = wr_byte;
      end
      // [R3] write goes to the latch only; [R4] merged value
      if (wr_port) begin
        latch_nxt = rmw_val;
      end
    end
  end

  // Change detection state
  always_comb begin
    // [R12] port access refreshes the copy
    ref_nxt = port_access ? pins : ref_r;
    // [R14] a change landing in the access cycle still sets the flag against the old copy
    // Software may write the flag; a live mismatch beats the clear
    flag_nxt = (wr_icr && wr_lane) ? wr_byte[CHG_FLAG_BIT] : flag_r;
    // [R13] mismatch keeps setting the flag
    if (mismatch_any) begin
      flag_nxt = 1'b1;
    end
  end

  // Side outputs derived from configuration and modes
  always_comb begin
    // [R5] pull-ups on when enable bit clear; [R6] inputs only
    pullup_nxt = {PORT_W{~opt_r[PULLUP_EN_N_BIT]}} & dir_r;
    // Other pins use TTL levels
    schmitt_nxt = '0;
    // [R15] Schmitt buffer on the edge interrupt input
    schmitt_nxt[EDGE_IRQ_BIT] = edge_irq_mode;
    // [R16] Schmitt buffers in serial programming mode
    schmitt_nxt[PROG_CLK_BIT] = serial_prog_mode;
    schmitt_nxt[PROG_DAT_BIT] = serial_prog_mode;
    // [R11] wake the core while it sleeps
    wake_nxt = sleep_active && flag_nxt;
  end

  // Pin synchroniser; the second stage alone feeds the logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= RST_SYNC;
      sync2_r <= RST_SYNC;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end
  // Configuration registers
  always_ff @(posedge aclk) begin
    // [R17] direction and option load all ones; [R7] pull-ups off
    if (!aresetn) begin
      dir_r <= RST_DIRECTION;
      opt_r <= RST_OPTION;
    end else begin
      dir_r <= dir_nxt;
      opt_r <= opt_nxt;
    end
  end
  // Output latch; any starting value is allowed, zero is chosen
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_r <= RST_LATCH;
    end else begin
      latch_r <= latch_nxt;
    end
  end
  // Comparison copy and change flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_r  <= RST_SYNC;
      flag_r <= 1'b0;
    end else begin
      ref_r  <= ref_nxt;
      flag_r <= flag_nxt;
    end
  end

  // Registered side outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pullup_r  <= '0;
      schmitt_r <= '0;
      wake_r    <= 1'b0;
    end else begin
      pullup_r  <= pullup_nxt;
      schmitt_r <= schmitt_nxt;
      wake_r    <= wake_nxt;
    end
  end

  // Write channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_st_r <= WR_IDLE;
      bresp_r <= RESP_OKAY;
    end else begin
      wr_st_r <= wr_st_nxt;
      bresp_r <= bresp_nxt;
    end
  end

  // Holding registers for a half-arrived write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_r <= '0;
      wdata_r  <= '0;
      wstrb_r  <= '0;
    end else begin
      if (aw_take) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
    end
  end

  // Read channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_st_r <= RD_IDLE;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else begin
      rd_st_r <= rd_st_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // [R2] drive latch value onto output pins
  assign pin_out = latch_r;
  // [R1] enable low only while direction bit is zero
  assign pin_oe_n = dir_r;
  // [R19] the far side must stay off pins whose enable is low
  assign pullup_on = pullup_r;
  assign schmitt_sel = schmitt_r;
  assign wake_req = wake_r;
  assign port_change_flag = flag_r;

  // Protection bits carry no meaning for this slave
  wire unused_prot = ^{s_axi_awprot, s_axi_arprot};

endmodule

// >>> verilog/bpc_pkg.sv
// Shared constants for the bidirectional port with change detection
package bpc_pkg;

  // Register bus geometry
  localparam int unsigned ADDR_W = 12;  // Byte address width
  localparam int unsigned DATA_W = 32;  // Bus data width
  localparam int unsigned PORT_W = 8;   // Port pin count

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PORT_DATA = 8'h06;  // second_port_data
  localparam logic [7:0] IDX_OPTION    = 8'h81;  // timer_and_pullup_config
  localparam logic [7:0] IDX_DIRECTION = 8'h86;  // second_port_direction
  localparam logic [7:0] IDX_INT_CTRL  = 8'h0b;  // interrupt_control_reg

  // Field positions
  localparam int unsigned PULLUP_EN_N_BIT = 7;  // pullup_enable_n in option
  localparam int unsigned EDGE_POL_BIT    = 6;  // edge_polarity_select
  localparam int unsigned CHG_FLAG_BIT    = 0;  // port_change_flag
  localparam int unsigned EDGE_IRQ_BIT    = 0;  // edge_irq_pin position
  localparam int unsigned PROG_CLK_BIT    = 6;  // Serial programming clock
  localparam int unsigned PROG_DAT_BIT    = 7;  // Serial programming data

  // Pins taking part in change detection (change_detect_pins)
  localparam logic [7:0] CHANGE_MASK = 8'hf0;

  // Values after reset
  localparam logic [7:0] RST_DIRECTION = 8'hff;  // All inputs
  localparam logic [7:0] RST_OPTION    = 8'hff;  // Pull-ups off
  localparam logic [7:0] RST_LATCH     = 8'h00;  // Output latch
  localparam logic [7:0] RST_SYNC      = 8'h00;  // Pin synchroniser stages

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Write channel states, Gray coded along both arrival orders
  typedef enum logic [1:0] {
    WR_IDLE = 2'h0,  // Nothing held
    WR_ADDR = 2'h1,  // Address held, waiting for data
    WR_RESP = 2'h3,  // Response pending
    WR_DATA = 2'h2   // Data held, waiting for address
  } bpc_wr_e;

  // Read channel states
  typedef enum logic {
    RD_IDLE = 1'b0,  // Ready for an address
    RD_RESP = 1'b1   // Read data pending
  } bpc_rd_e;

endpackage

// >>> sim/bpc_port_assertions.sv
// Concurrent checks on the port block's bus, pin and flag outputs
`timescale 1ns/10ps
module bpc_port_chk
  import bpc_pkg::*;
(
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // Bus signals watched
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  // Pins and status
  input wire logic [PORT_W-1:0] pin_in,
  input wire logic [PORT_W-1:0] pin_oe_n,
  input wire logic [PORT_W-1:0] pullup_on,
  input wire logic              edge_irq_mode,
  input wire logic              serial_prog_mode,
  input wire logic [PORT_W-1:0] schmitt_sel,
  input wire logic              sleep_active,
  input wire logic              wake_req,
  input wire logic              port_change_flag
);
  // Byte addresses, four times the register index
  localparam logic [11:0] A_PORT = {2'h0, IDX_PORT_DATA, 2'h0};
  localparam logic [11:0] A_OPT  = {2'h0, IDX_OPTION, 2'h0};
  localparam logic [11:0] A_DIR  = {2'h0, IDX_DIRECTION, 2'h0};
  localparam logic [11:0] A_ICTL = {2'h0, IDX_INT_CTRL, 2'h0};
  // Write taken in one edge, address and data together, with the low byte enabled
  wire logic       aw_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
  wire logic       ar_go = s_axi_arvalid && s_axi_arready;
  wire logic       ar_map = s_axi_araddr inside {A_PORT, A_OPT, A_DIR, A_ICTL};
  wire logic [7:0] wd_lo = s_axi_wdata[7:0];
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_dir_to_oe: assert property (aw_go && s_axi_awaddr == A_DIR |=> pin_oe_n == $past(wd_lo))
    else $error("pin enables do not follow direction write");
  chk_pullup_out_off: assert property ((pullup_on & ~$past(pin_oe_n)) == 8'h00)
    else $error("pull-up on an output pin");
  chk_reset_state: assert property ($rose(aresetn) |-> pin_oe_n == 8'hff && pullup_on == 8'h00)
    else $error("wrong pin state after reset");
  chk_flag_holds: assert property (
    port_change_flag && !(aw_go && s_axi_awaddr == A_ICTL) |=> port_change_flag)
    else $error("change flag dropped without a clear");
  chk_wake_follows: assert property (
    $past(aresetn) |-> wake_req == ($past(sleep_active) && port_change_flag))
    else $error("wake request does not follow flag");
  chk_schmitt_sel: assert property ($past(aresetn) |->
    schmitt_sel == {{2{$past(serial_prog_mode)}}, 5'h00, $past(edge_irq_mode)})
    else $error("input buffer selection wrong");
  chk_port_read: assert property (
    ar_go && s_axi_araddr == A_PORT && $past(aresetn, 3) && $stable(pin_in) &&
    $past(pin_in, 2) == pin_in |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(pin_in))
    else $error("port read is not the pin levels");
  chk_unmapped_read: assert property (
    ar_go && !ar_map |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  // Main scenarios reached
  cov_flag: cover property ($rose(port_change_flag));
  cov_wake: cover property (wake_req);
  cov_pullup: cover property (pullup_on != 8'h00);
endmodule

// >>> sim/bpc_pins.sv
// Pin-side model: keypad drivers, weak pull-ups and floating lines
`timescale 1ns/10ps
module bpc_pins (
  // Clock
  input  wire logic       aclk,
  // Device side
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  input  wire logic [7:0] pullup_on,
  // Keypad side, set by the bench
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  // Resolved wire level
  output logic [7:0]      pin_lvl
);
  logic [7:0] float_r = 8'h00;  // Wandering level of an undriven line
  // Undriven lines toggle so a stale level never passes for a real one
  always_ff @(posedge aclk) begin
    float_r <= ~pin_lvl;
  end
  // device drive wins, keypad drives only released pins
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pin_oe_n[i]) begin
        pin_lvl[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_lvl[i] = ext_val[i];
      end else if (pullup_on[i]) begin
        pin_lvl[i] = 1'b1;
      end else begin
        pin_lvl[i] = float_r[i];
      end
    end
  end
endmodule

// >>> sim/tb_bpc_port.sv
// Self-checking bench for the bidirectional change-detect port
`timescale 1ns/10ps
module tb_bpc_port;
  import bpc_pkg::*;
  // Byte addresses of the mapped registers
  localparam logic [11:0] A_PORT = {2'h0, IDX_PORT_DATA, 2'h0};
  localparam logic [11:0] A_OPT  = {2'h0, IDX_OPTION, 2'h0};
  localparam logic [11:0] A_DIR  = {2'h0, IDX_DIRECTION, 2'h0};
  localparam logic [11:0] A_ICTL = {2'h0, IDX_INT_CTRL, 2'h0};
  // Clock, reset and bus master side
  logic              aclk = 1'b0, aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [2:0]        s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [DATA_W-1:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]        s_axi_wstrb = 4'hf;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  // Pins, modes and keypad controls
  logic [7:0]        pin_in, pin_out, pin_oe_n, pullup_on, schmitt_sel;
  logic [7:0]        ext_en = 8'hff, ext_val = 8'h00;
  logic              edge_irq_mode = 1'b0, serial_prog_mode = 1'b0, sleep_active = 1'b0;
  logic              wake_req, port_change_flag;
  int                err_total = 0, checks = 0;

  bpc_port dut_u (.*);
  bpc_pins pins_u (.aclk(aclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_on(pullup_on),
                   .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_in));

  // 125 MHz clock
  always #4 aclk = ~aclk;

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bus write; address and data released each at its own handshake
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    logic pa, pw, ta, tw;
    logic [1:0] r;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw) begin
      @(negedge aclk);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      @(posedge aclk);
      if (ta) begin
        pa = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (tw) begin
        pw = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    cmp({30'h0, r}, {30'h0, er});
  endtask

  // Bus read; returns data and response
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er = RESP_OKAY);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    cmp(d, {24'h0, e});
    cmp({30'h0, r}, {30'h0, er});
  endtask

  // Pin changes need two sync stages plus the flag edge
  task automatic settle;
    repeat (4) @(posedge aclk);
  endtask

  task automatic t_reset;
    rchk(A_DIR, 8'hff);
    rchk(A_OPT, 8'hff);
    cmp({24'h0, pullup_on}, 32'h0);
    rchk(A_ICTL, 8'h00);
  endtask

  // Mixed direction: inputs overwrite latch bits, outputs drive latch
  task automatic t_drive;
    ext_val <= 8'ha3;
    settle();
    wr(A_PORT, 8'h55);
    // keypad lets go of the low nibble before it is driven
    ext_en <= 8'hf0;
    wr(A_DIR, 8'hf0);
    cmp({24'h0, pin_oe_n}, 32'hf0);
    cmp({24'h0, pin_out}, 32'ha3);
    settle();
    rchk(A_PORT, 8'ha3);
    wr(A_PORT, 8'h0c);
    cmp({24'h0, pin_out}, 32'hac);
  endtask

  // Pull-up enables are registered: look one edge after the write ends
  task automatic t_pullup;
    wr(A_OPT, 8'h7f);
    @(posedge aclk);
    cmp({24'h0, pullup_on}, 32'hf0);
    ext_en <= 8'h00;
    settle();
    rchk(A_PORT, 8'hfc);
    ext_en <= 8'hf0;
    ext_val <= 8'ha0;
    wr(A_OPT, 8'hff);
    @(posedge aclk);
    cmp({24'h0, pullup_on}, 32'h0);
  endtask

  task automatic t_change;
    ext_en <= 8'he0;
    wr(A_DIR, 8'he0);
    rchk(A_PORT, 8'hac);
    wr(A_ICTL, 8'h00);
    rchk(A_ICTL, 8'h00);
    wr(A_PORT, 8'h1c);
    // no polling of the port while waiting for a change
    settle();
    rchk(A_ICTL, 8'h00);
    sleep_active <= 1'b1;
    ext_val <= 8'h80;
    settle();
    cmp({31'h0, wake_req}, 32'h1);
    cmp({31'h0, port_change_flag}, 32'h1);
    rchk(A_ICTL, 8'h01);
    wr(A_ICTL, 8'h00);
    rchk(A_ICTL, 8'h01);
    rchk(A_PORT, 8'h9c);
    wr(A_ICTL, 8'h00);
    rchk(A_ICTL, 8'h00);
    sleep_active <= 1'b0;
    // Software may set the flag; no wake request while awake
    wr(A_ICTL, 8'h01);
    cmp({31'h0, port_change_flag}, 32'h1);
    cmp({31'h0, wake_req}, 32'h0);
    wr(A_ICTL, 8'h00);
    cmp({31'h0, port_change_flag}, 32'h0);
  endtask

  task automatic t_misc;
    rchk(12'h100, 8'h00, RESP_SLVERR);
    wr(12'h100, 8'hff, RESP_SLVERR);
    edge_irq_mode <= 1'b1;
    serial_prog_mode <= 1'b1;
    repeat (2) @(posedge aclk);
    cmp({24'h0, schmitt_sel}, 32'hc1);
    serial_prog_mode <= 1'b0;
    repeat (2) @(posedge aclk);
    cmp({24'h0, schmitt_sel}, 32'h01);
    rchk(A_DIR, 8'he0);
  endtask

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_drive();
    t_pullup();
    t_change();
    t_misc();
    report_and_stop();
  end

  // Watchdog: the whole run needs about a hundred and ten cycles
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    report_and_stop();
  end
endmodule

bind bpc_port bpc_port_chk chk_u (.*);
